// ==== rtl/set_skip_pkg.sv ====
// Package for the set-and-skip execution unit: opcodes, widths, constants.
// Assumes a single core clock and an external data memory read in the
// cycle an instruction is issued.
// Operation
// - The whole-byte set writes all ones into the addressed byte.
// - The single-bit set forces the selected bit of the byte to one.
// - Increment-and-skip writes the byte plus one back and skips on zero.
// - A taken skip drops the prefetch and adds a dummy cycle.
// - Increment-to-work puts byte plus one in the working register only.
// - The bit test skips the next instruction when the chosen bit is one.
package set_skip_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
  localparam int SKIP_CYCLES = 2;
  localparam int PLAIN_CYCLES = 1;

  typedef enum logic [2:0] {
    op_none = 3'h0,
    op_set_byte = 3'h1,
    op_set_bit = 3'h2,
    op_increment_skip_if_zero = 3'h3,
    op_increment_to_work_skip_if_zero = 3'h4,
    op_skip_if_bit_set = 3'h5
  } op_e;

  typedef enum logic [0:0] {
    st_exec = 1'h0,
    st_dummy = 1'h1
  } phase_e;

  typedef struct packed {
    op_e op;
    logic [ADDR_W-1:0] addr;
    logic [BIT_W-1:0] bit_sel;
  } issue_s;

  typedef struct packed {
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_wdata;
    logic work_we;
    logic [DATA_W-1:0] work_data;
    logic skip;
  } result_s;
endpackage : set_skip_pkg

// ==== rtl/set_skip_alu.sv ====
// Combinational result logic for the set and increment operations.
// Assumes the operand byte is the current content of the addressed cell.
`timescale 1ns/100ps
`default_nettype none
module set_skip_alu
  import set_skip_pkg::*;
(
  // Request
  input wire op_e op,
  input wire logic [BIT_W-1:0] bit_sel,
  input wire logic [DATA_W-1:0] operand,
  // Result
  output logic [DATA_W-1:0] value,
  output logic writes_mem,
  output logic writes_work,
  output logic skip
);
  logic [DATA_W-1:0] sum;
  logic [DATA_W-1:0] bit_mask;

  // modulo increment: the carry out is dropped by the target width.
  assign sum = DATA_W'(operand + ONE_BYTE);
  assign bit_mask = DATA_W'(ONE_BYTE << bit_sel);

  always_comb begin
    value = operand;
    writes_mem = 1'b0;
    writes_work = 1'b0;
    skip = 1'b0;
    case (op)
      op_set_byte: begin
        value = ALL_ONES;
        writes_mem = 1'b1;
      end
      op_set_bit: begin
        value = operand | bit_mask;
        writes_mem = 1'b1;
      end
      op_increment_skip_if_zero: begin
        value = sum;
        writes_mem = 1'b1;
        skip = (sum == ZERO_BYTE);
      end
      op_increment_to_work_skip_if_zero: begin
        value = sum;
        writes_work = 1'b1;
        skip = (sum == ZERO_BYTE);
      end
      op_skip_if_bit_set: begin
        skip = ((operand & bit_mask) != ZERO_BYTE);
      end
      default: begin
        value = operand;
      end
    endcase
  end
endmodule : set_skip_alu
`default_nettype wire

// ==== rtl/set_skip_exec.sv ====
// Execution unit for set, increment-skip and bit-test-skip instructions.
// Assumes decode presents one instruction per cycle with issue_valid, and
// that the memory read data for issue.addr is valid in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module set_skip_exec
  import set_skip_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Issue from decode
  input wire logic issue_valid,
  input wire issue_s issue,
  input wire logic [DATA_W-1:0] mem_rdata,
  // Results
  output result_s result,
  output logic [DATA_W-1:0] working_register,
  output logic flush_prefetch,
  output logic issue_ready
);
  typedef struct packed {
    phase_e phase;
    result_s res;
    logic [DATA_W-1:0] work;
    logic flush;
    logic ready;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic [DATA_W-1:0] alu_value;
  logic alu_mem;
  logic alu_work;
  logic alu_skip;
  logic take;

  set_skip_alu u_alu (
    .op(issue.op),
    .bit_sel(issue.bit_sel),
    .operand(mem_rdata),
    .value(alu_value),
    .writes_mem(alu_mem),
    .writes_work(alu_work),
    .skip(alu_skip)
  );

  assign take = issue_valid && cur.ready && (cur.phase == st_exec);

  always_comb begin
    next_cur = cur;
    next_cur.res.mem_we = 1'b0;
    next_cur.res.work_we = 1'b0;
    next_cur.res.skip = 1'b0;
    next_cur.flush = 1'b0;
    case (cur.phase)
      st_exec: begin
        next_cur.ready = 1'b1;
        if (take) begin
          next_cur.res.mem_addr = issue.addr;
          next_cur.res.mem_we = alu_mem;
          next_cur.res.mem_wdata = alu_value;
          next_cur.res.work_we = alu_work;
          next_cur.res.work_data = alu_value;
          if (alu_work) begin
            next_cur.work = alu_value;
          end
          if (alu_skip) begin
            next_cur.res.skip = 1'b1;
            next_cur.flush = 1'b1;
            next_cur.ready = 1'b0;
            next_cur.phase = st_dummy;
          end
        end
      end
      st_dummy: begin
        // The prefetched word is dropped here; decode refetches meanwhile.
        next_cur.ready = 1'b1;
        next_cur.phase = st_exec;
      end
      default: begin
        next_cur.phase = st_exec;
        next_cur.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  assign result = cur.res;
  assign working_register = cur.work;
  assign flush_prefetch = cur.flush;
  assign issue_ready = cur.ready;

  skip_two_cycles_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && take && alu_skip |=> !issue_ready ##1 issue_ready)
    else $error("skip did not take two cycles");
  plain_one_cycle_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && take && !alu_skip |=> issue_ready && !flush_prefetch)
    else $error("plain instruction stalled");
  // The flush is a single pulse, so the dummy cycle never drops a second word.
  flush_single_pulse_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && flush_prefetch |=> !flush_prefetch)
    else $error("flush lasted more than one cycle");
  set_byte_ones_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && take && issue.op == op_set_byte
    |=> result.mem_we && result.mem_wdata == ALL_ONES)
    else $error("byte set did not write all ones");
  set_bit_one_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && take && issue.op == op_set_bit
    |=> result.mem_we && result.mem_wdata[$past(issue.bit_sel)]
      && (result.mem_wdata & $past(mem_rdata)) == $past(mem_rdata))
    else $error("bit set failed");
  inc_write_back_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && take && issue.op == op_increment_skip_if_zero
    |=> result.mem_we && result.mem_wdata == 8'($past(mem_rdata) + ONE_BYTE)
      && result.skip == ($past(mem_rdata) == ALL_ONES))
    else $error("increment write back wrong");
  inc_to_work_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && take && issue.op == op_increment_to_work_skip_if_zero
    |=> !result.mem_we
      && working_register == 8'($past(mem_rdata) + ONE_BYTE))
    else $error("increment to work wrong");
  bit_test_skip_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && take && issue.op == op_skip_if_bit_set
    |=> flush_prefetch == $past(mem_rdata[issue.bit_sel]) && !result.mem_we)
    else $error("bit test skip wrong");
  wrap_zero_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && take && issue.op == op_increment_skip_if_zero
    && mem_rdata == ALL_ONES |=> result.mem_wdata == ZERO_BYTE
      && flush_prefetch)
    else $error("wrap to zero missed skip");
endmodule : set_skip_exec
`default_nettype wire

// ==== tb/set_and_skip_instructions_bench.sv ====
// Self-checking bench for the set-and-skip execution unit.
// Assumes the unit answers one cycle after it takes an instruction.
`timescale 1ns/100ps
`default_nettype none
module set_and_skip_instructions_bench;
  import set_skip_pkg::*;
  logic core_clk, rst, clk_en, issue_valid, flush_prefetch, issue_ready;
  issue_s issue;
  result_s result;
  logic [DATA_W-1:0] mem_rdata, working_register, work;
  int errors, comparisons;

  set_skip_exec i_set_skip_exec (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .issue_valid(issue_valid), .issue(issue), .mem_rdata(mem_rdata),
    .result(result), .working_register(working_register),
    .flush_prefetch(flush_prefetch), .issue_ready(issue_ready));

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // Issues one instruction and judges the answer one cycle later.
  task automatic run(input op_e op, input logic [2:0] b,
                     input logic [7:0] rd, input logic we,
                     input logic [7:0] wd, input logic wwe, input logic sk);
    int n;
    n = 0;
    @(posedge core_clk);
    issue_valid <= 1'b1;
    issue <= '{op, {4'h5, b}, b};
    mem_rdata <= rd;
    #1;
    while (issue_ready !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 4) begin
      errors++;
      end_sim();
    end
    @(posedge core_clk);
    issue_valid <= 1'b0;
    #1;
    if (wwe) work = wd;
    chk("mem_we", result.mem_we, we);
    if (we) chk("mem_wdata", result.mem_wdata, wd);
    if (we) chk("mem_addr", result.mem_addr, {4'h5, b});
    chk("work_we", result.work_we, wwe);
    if (wwe) chk("work_data", result.work_data, wd);
    chk("working_register", working_register, work);
    chk("skip", result.skip, sk);
    chk("flush", flush_prefetch, sk);
    chk("ready", issue_ready, !sk);
    if (sk) begin
      @(posedge core_clk);
      #1;
      chk("ready_after_dummy", issue_ready, 1'b1);
      chk("flush_pulse", flush_prefetch, 1'b0);
    end
  endtask : run

  task automatic t_set_byte;
    run(op_set_byte, 3'h0, 8'h3C, 1'b1, 8'hFF, 1'b0, 1'b0);
  endtask : t_set_byte

  task automatic t_set_bit;
    for (int i = 0; i < 8; i++) begin
      run(op_set_bit, 3'(i), 8'h00, 1'b1, 8'h01 << i, 1'b0, 1'b0);
      run(op_set_bit, 3'(i), 8'hA5, 1'b1, 8'hA5 | (8'h01 << i), 1'b0, 1'b0);
    end
  endtask : t_set_bit

  // Issues are spaced by an idle cycle; a taken skip's dummy cycle ends before the next issue.
  task automatic t_increment;
    run(op_increment_skip_if_zero, 3'h1, 8'h41, 1'b1, 8'h42, 1'b0, 1'b0);
    run(op_increment_skip_if_zero, 3'h1, 8'hFE, 1'b1, 8'hFF, 1'b0, 1'b0);
    run(op_increment_skip_if_zero, 3'h1, 8'hFF, 1'b1, 8'h00, 1'b0, 1'b1);
    run(op_increment_to_work_skip_if_zero, 3'h2, 8'h7F, 1'b0, 8'h80, 1'b1,
        1'b0);
    run(op_increment_to_work_skip_if_zero, 3'h2, 8'hFF, 1'b0, 8'h00, 1'b1,
        1'b1);
  endtask : t_increment

  task automatic t_bit_test;
    for (int i = 0; i < 8; i++) begin
      run(op_skip_if_bit_set, 3'(i), 8'h01 << i, 1'b0, 8'h00, 1'b0, 1'b1);
      run(op_skip_if_bit_set, 3'(i), ~(8'h01 << i), 1'b0, 8'h00, 1'b0, 1'b0);
    end
  endtask : t_bit_test

  // A frozen clock enable must hold off a pending write.
  task automatic t_freeze;
    @(posedge core_clk);
    clk_en <= 1'b0;
    issue_valid <= 1'b1;
    issue <= '{op_set_byte, 7'h11, 3'h0};
    repeat (3) @(posedge core_clk);
    #1;
    chk("frozen_mem_we", result.mem_we, 1'b0);
    @(posedge core_clk);
    issue_valid <= 1'b0;
    clk_en <= 1'b1;
  endtask : t_freeze

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    issue_valid = 1'b0;
    issue = '0;
    mem_rdata = '0;
    work = '0;
    errors = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_set_byte();
    t_set_bit();
    t_increment();
    t_bit_test();
    t_freeze();
    end_sim();
  end
endmodule : set_and_skip_instructions_bench
`default_nettype wire
